/* bench/fifo_fall_through_mode_flags_offset_load_bench.sv */
`timescale 1ns/1ps
module fifo_fall_through_mode_flags_offset_load_bench;
  localparam int DW   = 6;
  localparam int CAP  = 2**DW + 1;
  localparam int HALF = 2**(DW-1) + fof_pkg::HALF_EXTRA;
  localparam int DEF  = fof_pkg::OFS_DEF_SERIAL % (2**DW);

  // clock, reset and apb
  logic        ref_clk;
  logic        nrst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic        pready;
  logic        pslverr;
  logic        err;
  logic        serial_mode;
  logic        offsets_valid;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [31:0] rd;
  int          fails;
  int          num_checks;
  int          n_e;
  int          m_f;

  fof_if link ();

  fof_device #(.DEPTH_W(DW)) i_fof_device (.ref_clk(ref_clk), .nrst(nrst), .link(link.dev),
    .serial_mode(serial_mode), .offsets_valid(offsets_valid));
  fof_host #(.DEPTH_W(DW), .LD_AT_RESET(1'b1)) i_fof_host (.ref_clk(ref_clk), .nrst(nrst),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link.host));
  fof_link_sva #(.DEPTH_W(DW)) i_fof_link_sva (.ref_clk(ref_clk), .nrst(nrst),
    .offset_load_select(link.offset_load_select),
    .serial_load_enable_n(link.serial_load_enable_n), .write_en_n(link.write_en_n),
    .read_en_n(link.read_en_n), .input_ready_flag(link.input_ready_flag),
    .output_ready_flag(link.output_ready_flag), .almost_empty_flag(link.almost_empty_flag),
    .almost_full_flag(link.almost_full_flag), .half_full_flag(link.half_full_flag),
    .serial_mode(serial_mode), .offsets_valid(offsets_valid));

  // free-running clock
  always #5 ref_clk = ~ref_clk;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      $display("mismatch %s expected %0h seen %0h", what, exp, seen);
      fails++;
    end
  endtask

  // one apb transfer; pready is read before the edge's own updates land
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    // no local limit: only the watchdog ends a stuck wait
    do
      @(posedge ref_clk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // issue a command, then poll busy; rd ends holding the idle status
  task automatic cmd(input logic [2:0] c);
    apb(1'b1, fof_pkg::REG_CMD, {29'h0, c});
    do
      apb(1'b0, fof_pkg::REG_STATUS, 32'h0);
    while (rd[fof_pkg::STAT_BUSY] !== 1'b0);
  endtask

  // all fall-through flags against a word count
  task automatic flags(input int c);
    check("input_ready", link.input_ready_flag, c == CAP);
    check("output_ready", link.output_ready_flag, c == 0);
    check("almost_empty", link.almost_empty_flag, c > n_e + 1);
    check("half_full", link.half_full_flag, c < HALF);
    check("almost_full", link.almost_full_flag, c < CAP - m_f);
  endtask

  task automatic report_and_stop;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence: defaults, refused parallel write, two serial loads, fill, drain
  initial
  begin
    ref_clk = 1'b0;
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    fails = 0;
    num_checks = 0;
    n_e = DEF;
    m_f = DEF;
    repeat (4) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    check("load_method", serial_mode, 1);
    flags(0);
    cmd(fof_pkg::CMD_PAR_RD);
    check("empty_default", rd[9:1], DEF);
    cmd(fof_pkg::CMD_PAR_RD);
    check("full_default", rd[9:1], DEF);
    apb(1'b1, fof_pkg::REG_EOFS, 32'h3);
    apb(1'b1, fof_pkg::REG_FOFS, 32'h5);
    cmd(fof_pkg::CMD_PAR_WR);
    for (int j = 0; j < 2; j++)
    begin
      cmd(fof_pkg::CMD_PAR_RD);
      check("offset_kept", rd[9:1], DEF);
    end
    // second load proves reprogramming replaces the first
    for (int s = 0; s < 2; s++)
    begin
      n_e = s ? 3 : 1;
      m_f = s ? 5 : 2;
      apb(1'b1, fof_pkg::REG_EOFS, n_e);
      apb(1'b1, fof_pkg::REG_FOFS, m_f);
      cmd(fof_pkg::CMD_SER_LD);
      cmd(fof_pkg::CMD_PAR_RD);
      check("empty_offset", rd[9:1], n_e);
      cmd(fof_pkg::CMD_PAR_RD);
      check("full_offset", rd[9:1], m_f);
    end
    // one write past full must be refused
    for (int k = 1; k <= CAP + 1; k++)
    begin
      apb(1'b1, fof_pkg::REG_WDATA, k);
      cmd(fof_pkg::CMD_MEM_WR);
      flags(k > CAP ? CAP : k);
    end
    // one read past empty must be refused
    for (int k = 1; k <= CAP + 1; k++)
    begin
      cmd(fof_pkg::CMD_MEM_RD);
      if (k <= CAP)
        check("read_word", rd[9:1], k);
      flags(k > CAP ? 0 : CAP - k);
    end
    apb(1'b0, 8'h3C, 32'h0);
    check("unmapped_error", err, 1);
    report_and_stop();
  end

  // watchdog, well beyond the roughly 1500 cycles the sequence needs
  initial
  begin
    repeat (30000) @(posedge ref_clk);
    fails++;
    report_and_stop();
  end
endmodule

/* bench/fof_link_sva.sv */
`timescale 1ns/1ps
module fof_link_sva #(
  parameter int DEPTH_W = 16
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // link pins
  input wire logic offset_load_select,
  input wire logic serial_load_enable_n,
  input wire logic write_en_n,
  input wire logic read_en_n,
  input wire logic input_ready_flag,
  input wire logic output_ready_flag,
  input wire logic almost_empty_flag,
  input wire logic almost_full_flag,
  input wire logic half_full_flag,
  // device status
  input wire logic serial_mode,
  input wire logic offsets_valid
);
  localparam int CAP  = 2**DEPTH_W + 1;
  localparam int HALF = 2**(DEPTH_W-1) + fof_pkg::HALF_EXTRA;

  logic [DEPTH_W:0] cnt_q;
  logic [DEPTH_W:0] cnt_d;

  // accepted memory operations, refused ones leave the count alone
  wire mem_wr = offset_load_select && !write_en_n && !input_ready_flag;
  wire mem_rd = offset_load_select && !read_en_n && !output_ready_flag;
  wire shift  = serial_mode && !offset_load_select && !serial_load_enable_n
                && write_en_n && read_en_n;
  assign cnt_d = cnt_q + (DEPTH_W+1)'(mem_wr) - (DEPTH_W+1)'(mem_rd);

  // shadow word count, kept apart from the device so a stuck counter shows
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      cnt_q <= '0;
    else
      cnt_q <= cnt_d;
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  ////////////////////////////////////////////////////////////////////////////////
  property p_ir; input_ready_flag == (cnt_q == CAP); endproperty
  property p_or; output_ready_flag == (cnt_q == 0); endproperty
  property p_hf; half_full_flag == (cnt_q < HALF); endproperty
  property p_ae_low; offsets_valid && cnt_q <= 1 |-> !almost_empty_flag; endproperty
  property p_af_full; offsets_valid && cnt_q == CAP |-> !almost_full_flag; endproperty
  property p_shift_hides; shift |=> almost_empty_flag && almost_full_flag; endproperty
  property p_settle; shift |=> !offsets_valid ##1 !offsets_valid; endproperty
  property p_sen_idle;
    offsets_valid && !offset_load_select && serial_load_enable_n && write_en_n |=> offsets_valid;
  endproperty
  property p_mem_keep; offsets_valid && offset_load_select |=> $stable(offsets_valid); endproperty

  a_ir: assert property (p_ir) else $error("input ready disagrees with count");
  a_or: assert property (p_or) else $error("output ready disagrees with count");
  a_hf: assert property (p_hf) else $error("half full disagrees with count");
  a_ae_low: assert property (p_ae_low) else $error("almost empty high at low count");
  a_af_full: assert property (p_af_full) else $error("almost full high when full");
  a_shift_hides: assert property (p_shift_hides) else $error("flags shown mid load");
  a_settle: assert property (p_settle) else $error("offsets valid too early");
  a_sen_idle: assert property (p_sen_idle) else $error("load without enable");
  a_mem_keep: assert property (p_mem_keep) else $error("memory op broke offsets");

  // main scenarios reached
  c_shift: cover property (shift);
  c_full: cover property (cnt_q == CAP);
  c_valid: cover property ($rose(offsets_valid));
endmodule

/* common/fof_if.sv */
`timescale 1ns/1ps
interface fof_if;
  logic                         offset_load_select;
  logic                         serial_load_enable_n;
  logic                         write_en_n;
  logic                         read_en_n;
  logic                         serial_in;
  logic [fof_pkg::WORD_W-1:0]   input_word;
  logic [fof_pkg::WORD_W-1:0]   output_word;
  logic                         input_ready_flag;
  logic                         output_ready_flag;
  logic                         almost_empty_flag;
  logic                         almost_full_flag;
  logic                         half_full_flag;

  // the fifo end
  modport dev (
    input  offset_load_select, serial_load_enable_n, write_en_n, read_en_n,
    input  serial_in, input_word,
    output output_word, input_ready_flag, output_ready_flag,
    output almost_empty_flag, almost_full_flag, half_full_flag
  );

  // the system-logic end
  modport host (
    output offset_load_select, serial_load_enable_n, write_en_n, read_en_n,
    output serial_in, input_word,
    input  output_word, input_ready_flag, output_ready_flag,
    input  almost_empty_flag, almost_full_flag, half_full_flag
  );
endinterface

/* common/fof_pkg.sv */
package fof_pkg;

  // word and offset layout
  localparam int WORD_W  = 9;
  localparam int CHUNK_W = 8;
  localparam int MAX_SET = 64;

  // offset defaults picked by the load-select strap
  localparam int OFS_DEF_SERIAL   = 1023;
  localparam int OFS_DEF_PARALLEL = 127;

  // flag thresholds above the plain boundaries
  localparam int AE_EXTRA   = 2;
  localparam int HALF_EXTRA = 2;

  // write-clock edges after the last offset bit before flags are good
  localparam int SETTLE_EDGES = 2;

  // host register map, byte addresses
  localparam logic [7:0] REG_CMD    = 8'h00;
  localparam logic [7:0] REG_WDATA  = 8'h04;
  localparam logic [7:0] REG_EOFS   = 8'h08;
  localparam logic [7:0] REG_FOFS   = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_LDSEL  = 8'h14;

  // host command codes in REG_CMD[2:0]
  localparam logic [2:0] CMD_MEM_WR  = 3'h1;
  localparam logic [2:0] CMD_MEM_RD  = 3'h2;
  localparam logic [2:0] CMD_SER_LD  = 3'h3;
  localparam logic [2:0] CMD_PAR_WR  = 3'h4;
  localparam logic [2:0] CMD_PAR_RD  = 3'h5;

  // status field positions
  localparam int STAT_BUSY  = 0;
  localparam int STAT_RDATA = 1;
  localparam int STAT_IR    = 10;
  localparam int STAT_OR    = 11;
  localparam int STAT_AE    = 12;
  localparam int STAT_AF    = 13;
  localparam int STAT_HF    = 14;

  // parallel word index that holds bit i of the {full, empty} offset set
  function automatic int fof_word_of(input int i, input int ow);
    return (i / ow) * ((ow + CHUNK_W - 1) / CHUNK_W) + (i % ow) / CHUNK_W;
  endfunction

  // one parallel offset word, empty low byte first, full high byte last
  function automatic logic [WORD_W-1:0] fof_chunk(input logic [MAX_SET-1:0] v,
                                                 input int ow, input int w);
    logic [WORD_W-1:0] r;
    r = '0;
    for (int i = 0; i < 2 * ow; i++)
      if (fof_word_of(i, ow) == w)
        r[(i % ow) % CHUNK_W] = v[i];
    return r;
  endfunction

endpackage

/* src/fof_device.sv */
// What this block does
// - empty and full fall-through flag levels
// - almost-empty low up to n+1 words
// - half-full low from half plus two
// - almost-full low from capacity+1 minus m
// - empty offset default 127 or 1023
// - full offset default 127 or 1023
// - parallel offset writes in fixed order
// - parallel offset readback in same order
// - load method latched only at reset
// - parallel readback in either load method
// - same programming in both timing modes
// - one serial bit per write edge
// - controller supplies the whole serial set
// - partial flags invalid until set complete
// - serial reprogramming allowed any number of times
// - no shift while serial enable high
// - memory writes keep partial serial load
// - paused shift resumes at next bit
// - almost-full valid two write edges later
// - almost-empty valid two read edges later
// - no serial readback path
// - strap high serial 3FF, low parallel 07F
//
// Added by the designer: the register offsets and register access over APB.
`timescale 1ns/1ps
module fof_device #(
  parameter int DEPTH_W = 16
) (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic nrst,
  // link to the system logic
  fof_if.dev        link,
  // local status
  output logic      serial_mode,
  output logic      offsets_valid
);

  localparam int OW     = DEPTH_W;
  localparam int NW     = (OW + fof_pkg::CHUNK_W - 1) / fof_pkg::CHUNK_W;
  localparam int NWORDS = 2 * NW;
  localparam int SET_W  = 2 * OW;
  localparam int BIT_W  = $clog2(SET_W);
  localparam int PTR_W  = $clog2(NWORDS);
  localparam int CW     = DEPTH_W + 2;
  localparam logic [CW-1:0] CAP   = CW'((1 << DEPTH_W) + 1);
  localparam logic [CW-1:0] HF_AT = CW'((1 << (DEPTH_W - 1)) + fof_pkg::HALF_EXTRA);
  localparam logic [OW-1:0] DEF_S = OW'(fof_pkg::OFS_DEF_SERIAL);
  localparam logic [OW-1:0] DEF_P = OW'(fof_pkg::OFS_DEF_PARALLEL);
  localparam logic [1:0]    SETTLE = 2'(fof_pkg::SETTLE_EDGES - 1);

  // wrapping increment for the bit and word pointers
  function automatic int wrap_inc(input int v, input int lim);
    return (v == lim - 1) ? 0 : v + 1;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state

  logic                        init_q;
  logic                        serial_mode_q;
  logic [SET_W-1:0]            ofs_q;
  logic [SET_W-1:0]            ofs_d;
  logic [BIT_W-1:0]            bit_q;
  logic [PTR_W-1:0]            wptr_q;
  logic [PTR_W-1:0]            rptr_q;
  logic                        pend_q;
  logic [1:0]                  settle_q;
  logic [fof_pkg::WORD_W-1:0]  mem [0:(1 << DEPTH_W)-1];
  logic [DEPTH_W-1:0]          mwp_q;
  logic [DEPTH_W-1:0]          mrp_q;
  logic [DEPTH_W:0]            mcnt_q;
  logic                        ov_q;
  logic [fof_pkg::WORD_W-1:0]  dout_q;
  logic                        ir_q;
  logic                        or_q;
  logic                        ae_q;
  logic                        af_q;
  logic                        hf_q;
  logic                        valid_q;

  ////////////////////////////////////////////////////////////////////////////
  // operation decode; a memory write and read may share an edge, others one per edge

  wire ld    = link.offset_load_select;
  wire wen_n = link.write_en_n;
  wire ren_n = link.read_en_n;
  wire sen_n = link.serial_load_enable_n;

  wire [CW-1:0] tot_q = CW'(mcnt_q) + CW'(ov_q);
  wire full   = (tot_q == CAP);
  wire wr_mem = init_q & ld & ~wen_n & ~full;
  wire rd_mem = init_q & ld & ~ren_n & ov_q;
  wire shift  = init_q & serial_mode_q & ~ld & ~sen_n & wen_n & ren_n;
  wire pwr    = init_q & ~serial_mode_q & ~ld & ~wen_n & ren_n & sen_n;
  // readback is open in both load methods; serial-in has no reverse path
  wire prd    = init_q & ~ld & ~ren_n & wen_n & sen_n;

  wire last_bit = (bit_q == BIT_W'(SET_W - 1));
  wire last_wrd = (wptr_q == PTR_W'(NWORDS - 1));
  wire set_done = (shift & last_bit) | (pwr & last_wrd);
  // the shifting edge itself already hides the partial flags
  wire hold     = pend_q | shift | pwr | (settle_q != 2'h0);

  // fall-through head: memory feeds a one-word output stage
  wire load = (~ov_q | rd_mem) & (mcnt_q != '0);
  // a write into an empty path goes straight to the output stage, so
  // output-ready never lags the stored word count
  wire direct = wr_mem & (mcnt_q == '0) & (~ov_q | rd_mem);
  wire mem_we = wr_mem & ~direct;
  wire [DEPTH_W:0] mcnt_d = mcnt_q + (DEPTH_W+1)'(mem_we) - (DEPTH_W+1)'(load);
  wire ov_d = load | direct | (ov_q & ~rd_mem);
  wire [CW-1:0] tot_d = CW'(mcnt_d) + CW'(ov_d);

  wire [OW-1:0] n_ofs = ofs_q[OW-1:0];
  wire [OW-1:0] m_ofs = ofs_q[SET_W-1:OW];
  wire ae_low = (tot_d < CW'(n_ofs) + CW'(fof_pkg::AE_EXTRA));
  wire af_low = (tot_d >= CAP - CW'(m_ofs));
  wire hf_low = (tot_d >= HF_AT);
  wire ir_hi  = (tot_d == CAP);

  ////////////////////////////////////////////////////////////////////////////
  // next offset set: serial bit or one parallel word

  always_comb
  begin
    ofs_d = ofs_q;
    if (shift)
      ofs_d[bit_q] = link.serial_in;
    for (int i = 0; i < SET_W; i++)
      if (pwr && fof_pkg::fof_word_of(i, OW) == int'(wptr_q))
        ofs_d[i] = link.input_word[(i % OW) % fof_pkg::CHUNK_W];
  end

  ////////////////////////////////////////////////////////////////////////////
  // strap capture and offset programming; the same path serves both
  // timing modes, only fall-through flag decode is built here

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      init_q        <= 1'b0;
      serial_mode_q <= 1'b0;
      ofs_q         <= '0;
      bit_q         <= '0;
      wptr_q        <= '0;
      rptr_q        <= '0;
    end
    else if (!init_q)
    begin
      // first edge after release: strap read once, never again
      init_q        <= 1'b1;
      serial_mode_q <= ld;
      ofs_q         <= ld ? {DEF_S, DEF_S} : {DEF_P, DEF_P};
    end
    else
    begin
      ofs_q <= ofs_d;
      if (shift)
        bit_q <= BIT_W'(wrap_inc(int'(bit_q), SET_W));
      if (pwr)
        wptr_q <= PTR_W'(wrap_inc(int'(wptr_q), NWORDS));
      if (prd)
        rptr_q <= PTR_W'(wrap_inc(int'(rptr_q), NWORDS));
    end
  end

  // partial flags held inactive from first bit until settled
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pend_q   <= 1'b0;
      settle_q <= 2'h0;
    end
    else
    begin
      if (set_done)
      begin
        pend_q   <= 1'b0;
        settle_q <= SETTLE;
      end
      else
      begin
        if (shift | pwr)
          pend_q <= 1'b1;
        if (settle_q != 2'h0)
          settle_q <= settle_q - 2'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // storage and output stage

  always_ff @(posedge ref_clk)
  begin
    if (mem_we)
      mem[mwp_q] <= link.input_word;
  end

  // readback overwrites the word shown on the outputs
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      mwp_q  <= '0;
      mrp_q  <= '0;
      mcnt_q <= '0;
      ov_q   <= 1'b0;
      dout_q <= '0;
    end
    else
    begin
      mcnt_q <= mcnt_d;
      ov_q   <= ov_d;
      if (mem_we)
        mwp_q <= mwp_q + DEPTH_W'(1);
      if (load)
        mrp_q <= mrp_q + DEPTH_W'(1);
      if (prd)
        dout_q <= fof_pkg::fof_chunk(64'(ofs_q), OW, int'(rptr_q));
      else if (load)
        dout_q <= mem[mrp_q];
      else if (direct)
        dout_q <= link.input_word;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered fall-through flags, all active low; only the almost flags are held inactive during offset loads

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ir_q    <= 1'b0;
      or_q    <= 1'b1;
      ae_q    <= 1'b0;
      af_q    <= 1'b1;
      hf_q    <= 1'b1;
      valid_q <= 1'b0;
    end
    else
    begin
      ir_q    <= ir_hi;
      or_q    <= ~ov_d;
      hf_q    <= ~hf_low;
      ae_q    <= hold ? 1'b1 : ~ae_low;
      af_q    <= hold ? 1'b1 : ~af_low;
      valid_q <= init_q & ~hold;
    end
  end

  assign link.output_word       = dout_q;
  assign link.input_ready_flag  = ir_q;
  assign link.output_ready_flag = or_q;
  assign link.almost_empty_flag = ae_q;
  assign link.almost_full_flag  = af_q;
  assign link.half_full_flag    = hf_q;
  assign serial_mode            = serial_mode_q;
  assign offsets_valid          = valid_q;

endmodule

/* src/fof_host.sv */
`timescale 1ns/1ps
module fof_host #(
  parameter int   DEPTH_W     = 16,
  parameter logic LD_AT_RESET = 1'b0
) (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  // apb slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // link to the fifo
  fof_if.host              link
);

  localparam int OW     = DEPTH_W;
  localparam int NW     = (OW + fof_pkg::CHUNK_W - 1) / fof_pkg::CHUNK_W;
  localparam int NWORDS = 2 * NW;
  localparam int SET_W  = 2 * OW;

  typedef enum logic [2:0] {
    ST_IDLE, ST_MWR, ST_MRD, ST_SHIFT, ST_PWR, ST_PRD, ST_PCAP
  } fof_hst_t;

  fof_hst_t                    st_q;
  fof_hst_t                    st_d;
  logic [6:0]                  cnt_q;
  logic [6:0]                  cnt_d;
  logic [fof_pkg::WORD_W-1:0]  wdata_q;
  logic [OW-1:0]               eofs_q;
  logic [OW-1:0]               fofs_q;
  logic                        ldsel_q;
  logic [fof_pkg::WORD_W-1:0]  rdata_q;
  logic [31:0]                 prdata_q;
  logic                        pready_q;
  logic                        pslverr_q;
  logic                        ld_q, wen_q, ren_q, sen_q, si_q;
  logic [fof_pkg::WORD_W-1:0]  din_q;
  logic                        ld_d, wen_d, ren_d, sen_d, si_d;
  logic [fof_pkg::WORD_W-1:0]  din_d;

  ////////////////////////////////////////////////////////////////////////////
  // apb decode; one wait state, writes land on the pready edge

  wire acc    = psel & penable & ~pready_q;
  wire wr_tk  = psel & penable & pready_q & pwrite;
  wire mapped = (paddr == fof_pkg::REG_CMD) | (paddr == fof_pkg::REG_WDATA)
              | (paddr == fof_pkg::REG_EOFS) | (paddr == fof_pkg::REG_FOFS)
              | (paddr == fof_pkg::REG_STATUS) | (paddr == fof_pkg::REG_LDSEL);
  wire busy   = (st_q != ST_IDLE);
  wire cmd_go = wr_tk & (paddr == fof_pkg::REG_CMD) & ~busy;
  wire [2:0] cmd = pwdata[2:0];
  wire [SET_W-1:0] set_v = {fofs_q, eofs_q};

  wire [31:0] status = {17'h0, link.half_full_flag, link.almost_full_flag,
                        link.almost_empty_flag, link.output_ready_flag,
                        link.input_ready_flag, rdata_q, busy};
  wire [31:0] rd_mux =
      (paddr == fof_pkg::REG_WDATA)  ? 32'(wdata_q) :
      (paddr == fof_pkg::REG_EOFS)   ? 32'(eofs_q)  :
      (paddr == fof_pkg::REG_FOFS)   ? 32'(fofs_q)  :
      (paddr == fof_pkg::REG_STATUS) ? status       :
      (paddr == fof_pkg::REG_LDSEL)  ? 32'(ldsel_q) : 32'h0000_0000;

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      wdata_q   <= '0;
      eofs_q    <= '0;
      fofs_q    <= '0;
      ldsel_q   <= LD_AT_RESET;
    end
    else
    begin
      pready_q  <= acc;
      pslverr_q <= acc & ~mapped;
      prdata_q  <= acc & ~pwrite ? rd_mux : 32'h0000_0000;
      if (wr_tk && paddr == fof_pkg::REG_WDATA)
        wdata_q <= pwdata[fof_pkg::WORD_W-1:0];
      if (wr_tk && paddr == fof_pkg::REG_EOFS)
        eofs_q <= pwdata[OW-1:0];
      if (wr_tk && paddr == fof_pkg::REG_FOFS)
        fofs_q <= pwdata[OW-1:0];
      if (wr_tk && paddr == fof_pkg::REG_LDSEL)
        ldsel_q <= pwdata[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer; the whole serial set is always sent so no load is partial

  always_comb
  begin
    st_d  = st_q;
    cnt_d = cnt_q;
    case (st_q)
      ST_IDLE:
        if (cmd_go)
        begin
          cnt_d = 7'h00;
          case (cmd)
            fof_pkg::CMD_MEM_WR: st_d = ST_MWR;
            fof_pkg::CMD_MEM_RD: st_d = ST_MRD;
            fof_pkg::CMD_SER_LD: st_d = ST_SHIFT;
            fof_pkg::CMD_PAR_WR: st_d = ST_PWR;
            fof_pkg::CMD_PAR_RD: st_d = ST_PRD;
            default:             st_d = ST_IDLE;
          endcase
        end
      ST_SHIFT, ST_PWR:
      begin
        cnt_d = cnt_q + 7'h01;
        if (cnt_q == 7'((st_q == ST_SHIFT) ? SET_W - 1 : NWORDS - 1))
          st_d = ST_IDLE;
      end
      ST_PRD:  st_d = ST_PCAP;
      default: st_d = ST_IDLE;
    endcase
  end

  // pin levels for the coming cycle, registered below
  always_comb
  begin
    ld_d  = (st_d == ST_IDLE) ? ldsel_q : (st_d == ST_MWR) | (st_d == ST_MRD);
    wen_d = ~((st_d == ST_MWR) | (st_d == ST_PWR));
    ren_d = ~((st_d == ST_MRD) | (st_d == ST_PRD));
    sen_d = ~(st_d == ST_SHIFT);
    si_d  = (st_d == ST_SHIFT) ? set_v[cnt_d[$clog2(SET_W)-1:0]] : 1'b0;
    din_d = (st_d == ST_PWR) ? fof_pkg::fof_chunk(64'(set_v), OW, int'(cnt_d)) :
            (st_d == ST_MWR) ? wdata_q : '0;
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_q    <= ST_IDLE;
      cnt_q   <= 7'h00;
      rdata_q <= '0;
      ld_q    <= LD_AT_RESET;
      wen_q   <= 1'b1;
      ren_q   <= 1'b1;
      sen_q   <= 1'b1;
      si_q    <= 1'b0;
      din_q   <= '0;
    end
    else
    begin
      st_q  <= st_d;
      cnt_q <= cnt_d;
      ld_q  <= ld_d;
      wen_q <= wen_d;
      ren_q <= ren_d;
      sen_q <= sen_d;
      si_q  <= si_d;
      din_q <= din_d;
      // fall-through head is on the pins before the consuming edge
      if (st_q == ST_MRD || st_q == ST_PCAP)
        rdata_q <= link.output_word;
    end
  end

  assign link.offset_load_select   = ld_q;
  assign link.write_en_n           = wen_q;
  assign link.read_en_n            = ren_q;
  assign link.serial_load_enable_n = sen_q;
  assign link.serial_in            = si_q;
  assign link.input_word           = din_q;
  assign prdata                    = prdata_q;
  assign pready                    = pready_q;
  assign pslverr                   = pslverr_q;

endmodule
